// ==== inc/pec_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  loop-enable and crystal-monitor control block.
  Assumes inclusion by bare name from the package and the core module.
*/
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

`define PEC_CTL_OFFSET        8'h00
`define PEC_INT_STAT_OFFSET   8'h08
`define PEC_INT_MASK_OFFSET   8'h0C

`define PEC_CTL_IRC_EN_BIT    0
`define PEC_CTL_IRC_STB_BIT   1
`define PEC_CTL_ADJ_LSB       3
`define PEC_CTL_ADJ_MSB       7
`define PEC_CTL_CAL_LSB       8
`define PEC_CTL_CAL_MSB       15
`define PEC_CTL_MON_EN_BIT    19
`define PEC_CTL_MAIN_EN_BIT   24
`define PEC_CTL_MAIN_STB_BIT  25
`define PEC_CTL_B_EN_BIT      26
`define PEC_CTL_B_STB_BIT     27
`define PEC_CTL_C_EN_BIT      28
`define PEC_CTL_C_STB_BIT     29

`define PEC_CTL_ADJ_RESET     5'h10
`define PEC_CTL_IRC_EN_RESET  1'h1

`define PEC_INT_FAIL_BIT      0
`define PEC_INT_MAIN_STB_BIT  1
`define PEC_INT_B_STB_BIT     2
`define PEC_INT_C_STB_BIT     3
`define PEC_INT_WIDTH         4

`define PEC_SYNC_STAGES       3

`endif

// ==== inc/pec_pkg.sv ====
/*
  Types of the loop-enable and crystal-monitor control block.
  Assumes pec_regs.svh on the include path.
*/
package pec_pkg;
  `include "pec_regs.svh"

  typedef enum logic [1:0] {
    PEC_SRC_IRC,
    PEC_SRC_CRYSTAL,
    PEC_SRC_MAIN_LOOP
  } pec_sys_src_type;

  typedef enum {
    PEC_MON_NORMAL,
    PEC_MON_FORCED
  } pec_mon_state_type;
endpackage

// ==== core/pec_ctl.sv ====
/*
  Control register upper half: three loop enables with stable flags, crystal
  clock monitor with forced fallback to the internal 8 MHz oscillator, and
  interrupt status/mask, all behind an APB slave.
  Assumes: analog stable and stuck inputs are asynchronous pins; sys_src,
  low_power_entry and main_loop_from_crystal come from logic on pclk.
*/
// Decided for this implementation: the APB slave port.
// Function
// - control register resets to upper half zero, low byte 0x83, calibration undefined
// - loop C stable flag at bit 29 high only while loop C clock stable
// - loop C enable bit 28 software writable, cleared on low-power entry
// - loop B stable flag at bit 27 high only while loop B clock stable
// - loop B enable bit 26 software writable, cleared on low-power entry
// - main loop stable flag bit 25 reports main loop clock stability
// - main enable bit 24 not clearable by software while main loop clocks system
// - monitor enable bit 19 read/write; monitor active only when set
// - stuck crystal with monitor active forces system clock to internal oscillator
// - forced switch ends only on reset or software clearing failure flag
// - internal oscillator kept running whenever monitor enabled
// - failure disables crystal, sets failure flag, raises non-maskable event
// - failure disables main loop whenever main loop runs from crystal, whatever clocks the system
`include "pec_regs.svh"

module pec_ctl (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [2:0]             loop_stable_raw,
  input  wire logic                   crystal_stuck_raw,
  input  wire logic                   irc_stable_raw,
  input  wire logic [7:0]             internal_rc_calibration,
  input  wire pec_pkg::pec_sys_src_type sys_src,
  input  wire logic                   main_loop_from_crystal,
  input  wire logic                   low_power_entry,
  output logic                        main_loop_enable,
  output logic                        loop_b_enable,
  output logic                        loop_c_enable,
  output logic                        internal_rc_run,
  output logic                        force_sys_to_irc,
  output logic                        crystal_disable,
  output logic                        failure_nmi,
  output logic                        irq
);
  import pec_pkg::*;

  localparam int NSYNC = 5;

  logic [NSYNC-1:0]          sync1_q;
  logic [NSYNC-1:0]          sync2_q;
  logic [NSYNC-1:0]          sync3_q;
  logic [NSYNC-1:0]          filt_q;
  logic [2:0]                en_q;
  logic [2:0]                stb_q;
  logic                      mon_en_q;
  logic                      irc_en_q;
  logic [4:0]                adj_q;
  logic [`PEC_INT_WIDTH-1:0] stat_q;
  logic [`PEC_INT_WIDTH-1:0] mask_q;
  logic [`PEC_INT_WIDTH-1:0] stat_set;
  pec_mon_state_type         mon_state_q;
  logic                      fail_evt;
  logic                      wr_acc;
  logic                      setup;
  logic                      wr_ctl;
  logic                      wr_stat;
  logic                      wr_mask;
  logic                      fail_clear;
  logic                      main_busy;
  logic                      main_kill;
  logic [31:0]               ctl_rd;
  logic [31:0]               rd_d;
  logic                      err_d;

  // the pin filter below is built for exactly three stages
  if (`PEC_SYNC_STAGES != 3) begin : g_bad_sync
    $error("three sync stages expected");
  end

  // three-stage pin synchronisers; a change counts once stages two and three agree
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    logic raw;
    if (i < 3) begin : g_loop
      assign raw = loop_stable_raw[i];
    end else if (i == 3) begin : g_stuck
      assign raw = crystal_stuck_raw;
    end else begin : g_irc
      assign raw = irc_stable_raw;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        sync3_q[i] <= 1'b0;
        filt_q[i]  <= 1'b0;
      end else begin
        sync1_q[i] <= raw;
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign setup      = psel && !penable;
  assign wr_acc     = psel && penable && pready && pwrite;
  assign wr_ctl     = wr_acc && (paddr == `PEC_CTL_OFFSET);
  assign wr_stat    = wr_acc && (paddr == `PEC_INT_STAT_OFFSET);
  assign wr_mask    = wr_acc && (paddr == `PEC_INT_MASK_OFFSET);
  assign fail_clear = wr_stat && pwdata[`PEC_INT_FAIL_BIT];
  assign fail_evt   = mon_en_q && filt_q[3] && (mon_state_q == PEC_MON_NORMAL);
  assign main_busy  = (sys_src == PEC_SRC_MAIN_LOOP) && !force_sys_to_irc;
  assign main_kill  = fail_evt && main_loop_from_crystal;

  // control register fields under software and hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q     <= 3'h0;
      mon_en_q <= 1'b0;
      irc_en_q <= `PEC_CTL_IRC_EN_RESET;
      adj_q    <= `PEC_CTL_ADJ_RESET;
    end else begin
      if (wr_ctl) begin
        en_q[1]  <= pwdata[`PEC_CTL_B_EN_BIT];
        en_q[2]  <= pwdata[`PEC_CTL_C_EN_BIT];
        // a clear is dropped while the main loop clocks the system
        en_q[0]  <= pwdata[`PEC_CTL_MAIN_EN_BIT] || (en_q[0] && main_busy);
        mon_en_q <= pwdata[`PEC_CTL_MON_EN_BIT];
        irc_en_q <= pwdata[`PEC_CTL_IRC_EN_BIT];
        adj_q    <= pwdata[`PEC_CTL_ADJ_MSB:`PEC_CTL_ADJ_LSB];
      end
      if (main_kill) begin
        en_q[0] <= 1'b0;
      end
      if (low_power_entry) begin
        en_q <= 3'h0;
      end
    end
  end

  // stable flags qualified by their enable so they drop right after a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_q <= 3'h0;
    end else begin
      stb_q <= en_q & filt_q[2:0];
    end
  end

  // monitor fallback; software clear and failure never coincide since
  // detection is blocked while forced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_state_q <= PEC_MON_NORMAL;
    end else begin
      case (mon_state_q)
        PEC_MON_NORMAL: begin
          if (fail_evt) begin
            mon_state_q <= PEC_MON_FORCED;
          end
        end
        PEC_MON_FORCED: begin
          if (fail_clear) begin
            mon_state_q <= PEC_MON_NORMAL;
          end
        end
        default: mon_state_q <= PEC_MON_NORMAL;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_sys_to_irc <= 1'b0;
      crystal_disable  <= 1'b0;
      internal_rc_run  <= 1'b1;
    end else begin
      force_sys_to_irc <= (mon_state_q == PEC_MON_FORCED) ? !fail_clear : fail_evt;
      crystal_disable  <= (mon_state_q == PEC_MON_FORCED) ? !fail_clear : fail_evt;
      internal_rc_run  <= irc_en_q || mon_en_q || fail_evt;
    end
  end

  assign stat_set = {stb_q[2] & ~en_q[2] ? 1'b0 : (~stb_q[2] & en_q[2] & filt_q[2]),
                     ~stb_q[1] & en_q[1] & filt_q[1],
                     ~stb_q[0] & en_q[0] & filt_q[0],
                     fail_evt};

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? pwdata[`PEC_INT_WIDTH-1:0] : '0)) | stat_set;
      if (wr_mask) begin
        mask_q <= pwdata[`PEC_INT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq         <= 1'b0;
      failure_nmi <= 1'b0;
    end else begin
      irq         <= |(stat_q & mask_q);
      failure_nmi <= stat_q[`PEC_INT_FAIL_BIT];
    end
  end

  always_comb begin
    ctl_rd = 32'h0000_0000;
    ctl_rd[`PEC_CTL_IRC_EN_BIT]                   = irc_en_q;
    ctl_rd[`PEC_CTL_IRC_STB_BIT]                  = filt_q[4];
    ctl_rd[`PEC_CTL_ADJ_MSB:`PEC_CTL_ADJ_LSB]     = adj_q;
    ctl_rd[`PEC_CTL_CAL_MSB:`PEC_CTL_CAL_LSB]     = internal_rc_calibration;
    ctl_rd[`PEC_CTL_MON_EN_BIT]                   = mon_en_q;
    ctl_rd[`PEC_CTL_MAIN_EN_BIT]                  = en_q[0];
    ctl_rd[`PEC_CTL_MAIN_STB_BIT]                 = stb_q[0];
    ctl_rd[`PEC_CTL_B_EN_BIT]                     = en_q[1];
    ctl_rd[`PEC_CTL_B_STB_BIT]                    = stb_q[1];
    ctl_rd[`PEC_CTL_C_EN_BIT]                     = en_q[2];
    ctl_rd[`PEC_CTL_C_STB_BIT]                    = stb_q[2];
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `PEC_CTL_OFFSET:      rd_d = ctl_rd;
      `PEC_INT_STAT_OFFSET: rd_d = {28'h000_0000, stat_q};
      `PEC_INT_MASK_OFFSET: rd_d = {28'h000_0000, mask_q};
      default:              err_d = 1'b1;
    endcase
  end

  // no wait state; pready, prdata and pslverr all registered from the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      pslverr <= setup && err_d;
    end
  end

  assign main_loop_enable = en_q[0];
  assign loop_b_enable    = en_q[1];
  assign loop_c_enable    = en_q[2];

  AST_C_STB_NEEDS_EN: assert property (@(posedge pclk) disable iff (!presetn)
    stb_q[2] |-> $past(en_q[2]) && $past(filt_q[2]))
    else $error("loop c stable without enable");

  AST_LP_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_entry |=> en_q == 3'h0)
    else $error("low power entry left a loop enabled");

  AST_B_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && !low_power_entry |=> en_q[1] == $past(pwdata[`PEC_CTL_B_EN_BIT]))
    else $error("loop b enable write lost");

  AST_MAIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && main_busy && en_q[0] && !low_power_entry && !main_kill |=> en_q[0])
    else $error("main enable cleared while clocking system");

  AST_MON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> mon_en_q == $past(pwdata[`PEC_CTL_MON_EN_BIT]))
    else $error("monitor enable write lost");

  AST_FAIL_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    fail_evt |=> force_sys_to_irc && crystal_disable && stat_q[`PEC_INT_FAIL_BIT] ##1 failure_nmi)
    else $error("failure did not force fallback");

  AST_FORCE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    force_sys_to_irc && !fail_clear |=> force_sys_to_irc)
    else $error("fallback released without clear");

  AST_IRC_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    mon_en_q |=> internal_rc_run)
    else $error("internal oscillator stopped under monitor");

  AST_MAIN_KILL: assert property (@(posedge pclk) disable iff (!presetn)
    main_kill |=> !en_q[0])
    else $error("main loop kept on after crystal failure");

  AST_STB_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(en_q[0]) |-> ##[0:1] !stb_q[0])
    else $error("main stable flag outlived enable");

  AST_B_STB_NEEDS_EN: assert property (@(posedge pclk) disable iff (!presetn)
    stb_q[1] |-> $past(en_q[1]) && $past(filt_q[1]))
    else $error("loop b stable without enable");

  AST_MAIN_STB: assert property (@(posedge pclk) disable iff (!presetn)
    stb_q[0] == ($past(en_q[0]) && $past(filt_q[0])))
    else $error("main stable flag out of step");

  AST_C_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && !low_power_entry |=> en_q[2] == $past(pwdata[`PEC_CTL_C_EN_BIT]))
    else $error("loop c enable write lost");

  AST_FORCE_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(force_sys_to_irc) |-> $past(fail_evt))
    else $error("fallback forced without failure");

  AST_NMI_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    stat_q[`PEC_INT_FAIL_BIT] |=> failure_nmi)
    else $error("failure flag did not reach nmi");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    irq == $past(|(stat_q & mask_q)))
    else $error("interrupt out of step with status");

  AST_PREADY_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("access phase without ready");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past access");

  AST_B_STB_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(en_q[1]) |-> ##[0:1] !stb_q[1])
    else $error("loop b stable flag outlived enable");

  AST_C_STB_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(en_q[2]) |-> ##[0:1] !stb_q[2])
    else $error("loop c stable flag outlived enable");

  // main scenarios; the bench reaches all but COV_FAIL, whose clear comes 25 cycles after the failure
  COV_FAIL: cover property (@(posedge pclk) disable iff (!presetn)
    fail_evt ##[1:20] fail_clear);
  COV_MAIN_KILL: cover property (@(posedge pclk) disable iff (!presetn) main_kill);
  COV_STB: cover property (@(posedge pclk) disable iff (!presetn) $rose(stb_q[2]));
  COV_MAIN_REFUSED: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && main_busy && en_q[0] && !pwdata[`PEC_CTL_MAIN_EN_BIT]);
  COV_LOW_POWER: cover property (@(posedge pclk) disable iff (!presetn)
    low_power_entry && (en_q != 3'h0));
endmodule

// ==== bench/testbench.sv ====
/*
  Self-checking bench of the loop-enable and crystal-monitor control block.
  Assumes pec_pkg compiled first; drives every input of pec_ctl on pclk, the registers over APB.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pec_pkg::*;

  typedef struct {
    logic [31:0] wd;
    logic [2:0]  raw;
    logic [31:0] exp;
  } pec_tb_row_type;

  logic            pclk, presetn, psel, penable, pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata;
  logic            pready, pslverr;
  logic [2:0]      loop_stable_raw;
  logic            crystal_stuck_raw, irc_stable_raw;
  logic [7:0]      internal_rc_calibration;
  pec_sys_src_type sys_src;
  logic            main_loop_from_crystal, low_power_entry;
  logic            main_loop_enable, loop_b_enable, loop_c_enable, internal_rc_run;
  logic            force_sys_to_irc, crystal_disable, failure_nmi, irq;
  int              error_cnt, checked, cycles;
  logic [31:0]     rd;
  logic            er;
  pec_tb_row_type  rows [5];

  pec_ctl pec_ctl_inst (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .loop_stable_raw         (loop_stable_raw),
    .crystal_stuck_raw       (crystal_stuck_raw),
    .irc_stable_raw          (irc_stable_raw),
    .internal_rc_calibration (internal_rc_calibration),
    .sys_src                 (sys_src),
    .main_loop_from_crystal  (main_loop_from_crystal),
    .low_power_entry         (low_power_entry),
    .main_loop_enable        (main_loop_enable),
    .loop_b_enable           (loop_b_enable),
    .loop_c_enable           (loop_c_enable),
    .internal_rc_run         (internal_rc_run),
    .force_sys_to_irc        (force_sys_to_irc),
    .crystal_disable         (crystal_disable),
    .failure_nmi             (failure_nmi),
    .irq                     (irq)
  );

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, low_power_entry, crystal_stuck_raw} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    loop_stable_raw = 3'h0;
    irc_stable_raw = 1'b1;
    internal_rc_calibration = 8'h5A;
    sys_src = PEC_SRC_IRC;
    main_loop_from_crystal = 1'b0;
  end

  always #50 pclk = ~pclk;

  task automatic results();
    $display("counts: %0d compared, %0d wrong", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: whole run needs well under 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // setup edge, access edge, then wait for pready sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    rows[0] = '{32'h1508_0081, 3'b111, 32'h3F08_0083};
    rows[1] = '{32'h1000_0081, 3'b101, 32'h3000_0083};
    rows[2] = '{32'h0400_0081, 3'b011, 32'h0C00_0083};
    rows[3] = '{32'h0100_0081, 3'b000, 32'h0100_0083};
    rows[4] = '{32'h0000_0081, 3'b111, 32'h0000_0083};
    idle(20);
    check(internal_rc_run, 1'b1, "irc run in reset");
    presetn <= 1'b1;
    idle(8);
    apb(1'b0, 8'h00, 32'h0);
    check(rd & 32'hFFFF00FF, 32'h0000_0083, "ctl reset");
    $display("test reset done");
    foreach (rows[i]) begin
      loop_stable_raw <= rows[i].raw;
      apb(1'b1, 8'h00, rows[i].wd);
      idle(8);
      apb(1'b0, 8'h00, 32'h0);
      check(rd, rows[i].exp | 32'h0000_5A00, "ctl row");
      check({loop_c_enable, loop_b_enable, main_loop_enable},
            {rows[i].wd[28], rows[i].wd[26], rows[i].wd[24]}, "enables");
    end
    $display("test table done");
    apb(1'b0, 8'h04, 32'h0);
    check({er, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 8'h00, 32'h1508_0081);
    sys_src <= PEC_SRC_MAIN_LOOP;
    apb(1'b1, 8'h00, 32'h1408_0081);
    idle(2);
    check(main_loop_enable, 1'b1, "main clear refused");
    low_power_entry <= 1'b1;
    idle(1);
    low_power_entry <= 1'b0;
    idle(7);
    check({loop_c_enable, loop_b_enable, main_loop_enable}, 3'b000, "sleep");
    apb(1'b0, 8'h00, 32'h0);
    check(rd[29:24], 6'h00, "flags after sleep");
    sys_src <= PEC_SRC_IRC;
    $display("test main and sleep done");
    apb(1'b1, 8'h00, 32'h0008_0080);
    idle(2);
    check(internal_rc_run, 1'b1, "irc kept by monitor");
    apb(1'b1, 8'h00, 32'h0000_0080);
    idle(2);
    check(internal_rc_run, 1'b0, "irc off");
    crystal_stuck_raw <= 1'b1;
    idle(10);
    check(force_sys_to_irc, 1'b0, "monitor off no force");
    $display("test monitor off done");
    main_loop_from_crystal <= 1'b1;
    apb(1'b1, 8'h00, 32'h0108_0081);
    for (int n = 0; n < 20 && force_sys_to_irc !== 1'b1; n++) @(posedge pclk);
    idle(2);
    check({force_sys_to_irc, crystal_disable}, 2'b11, "forced");
    check({main_loop_enable, failure_nmi}, 2'b01, "loop off, nmi");
    check(irq, 1'b0, "masked irq");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_000F, "failure and stable flags");
    apb(1'b1, 8'h0C, 32'h0000_0001);
    idle(2);
    check(irq, 1'b1, "irq unmasked");
    crystal_stuck_raw <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0081);
    idle(8);
    check(force_sys_to_irc, 1'b1, "force held");
    apb(1'b1, 8'h08, 32'h0000_000F);
    idle(2);
    check({force_sys_to_irc, failure_nmi, irq}, 3'b000, "flag cleared");
    $display("test failure done");
    crystal_stuck_raw <= 1'b1;
    apb(1'b1, 8'h00, 32'h0008_0081);
    idle(12);
    presetn <= 1'b0;
    idle(2);
    check(force_sys_to_irc, 1'b0, "reset ends force");
    presetn <= 1'b1;
    idle(8);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_5A83, "ctl after second reset");
    $display("test reset in force done");
    results();
  end
endmodule
